// ==== rtl/csw_pkg.sv ====
// constants, register map and state record of the cyclic sense and wake timers
package csw_pkg;
  localparam int NUM_TMR = 2;
  localparam int NUM_WK  = 2;
  localparam int CW      = 15;  // width of a tick count

  // clock and timing
  localparam int CLK_NS      = 25;
  localparam int TICK_NS     = 100000;  // timer resolution 0.1 ms
  localparam int TICK_CYC    = TICK_NS / CLK_NS;
  localparam int RESTART_NS  = 10000;   // reset output low time in restart
  localparam int RESTART_CYC = RESTART_NS / CLK_NS;

  // register byte offsets
  localparam logic [3:0] ADDR_TIMER = 4'h0;
  localparam logic [3:0] ADDR_HSCFG = 4'h4;
  localparam logic [3:0] ADDR_MODE  = 4'h8;
  localparam logic [3:0] ADDR_STAT  = 4'hc;

  // field positions
  localparam int TMR_STRIDE   = 8;   // timer t at bit 8*t
  localparam int TMR_PER_POS  = 0;   // period code [2:0]
  localparam int TMR_ON_POS   = 4;   // on-time code [2:0]
  localparam int HS_STRIDE    = 4;   // high side i at bit 4*i
  localparam int HS_INIT_POS  = 2;   // map [1:0], initial level [2]
  localparam int HS_STAT_POS  = 8;   // static wake enable per input
  localparam int MODE_SYNC_POS = 4;  // timer 0 follows external sync
  localparam int ST_CW_POS    = 2;
  localparam int ST_DS_POS    = 4;
  localparam int ST_FAIL_POS  = 5;
  localparam int ST_LVL_POS   = 8;
  localparam int ST_MODE_POS  = 16;
  localparam int ST_DIS_POS   = 24;

  // on-time codes that switch a timer off
  localparam logic [2:0] ON_OFF0 = 3'h0;
  localparam logic [2:0] ON_OFF6 = 3'h6;
  localparam logic [2:0] ON_OFF7 = 3'h7;

  // period and on-time in ticks, indexed by code
  localparam logic [7:0][CW-1:0] PERIOD_TICKS = '{15'h4e20, 15'h2710, 15'h1388, 15'h07d0,
                                                 15'h03e8, 15'h01f4, 15'h00c8, 15'h0064};
  localparam logic [7:0][CW-1:0] ON_TICKS = '{15'h0000, 15'h0000, 15'h00c8, 15'h0064,
                                             15'h000a, 15'h0003, 15'h0001, 15'h0000};

  // mode request codes
  localparam logic [1:0] REQ_NORMAL = 2'h0;
  localparam logic [1:0] REQ_STOP   = 2'h1;
  localparam logic [1:0] REQ_SLEEP  = 2'h2;

  typedef enum logic [4:0] {
    MODE_NORMAL   = 5'h01,
    MODE_STOP     = 5'h02,
    MODE_SLEEP    = 5'h04,
    MODE_RESTART  = 5'h08,
    MODE_FAILSAFE = 5'h10
  } csw_mode_t;

  typedef struct packed {
    logic [2:0] on;
    logic [2:0] period;
  } csw_tmr_cfg_t;

  typedef struct packed {
    csw_tmr_cfg_t [NUM_TMR-1:0]         tmr_cfg;
    logic [NUM_TMR-1:0][CW-1:0]         tmr_cnt;
    logic [11:0]                        tick_cnt;
    logic [NUM_WK-1:0][1:0]             hs_map;
    logic [NUM_WK-1:0]                  hs_init;
    logic [NUM_WK-1:0]                  hs_dis;
    logic [NUM_WK-1:0]                  static_en;
    logic                               sync_sel;
    logic                               sync_prev;
    logic [NUM_WK-1:0]                  wk_prev;
    logic [NUM_WK-1:0]                  wk_lvl;
    logic [NUM_WK-1:0]                  wk_flag;
    logic [NUM_TMR-1:0]                 cw_flag;
    logic                               ds_flag;
    logic                               spi_fail;
    csw_mode_t                          mode;
    logic [8:0]                         rst_cnt;
    logic [NUM_WK-1:0]                  hs_out;
    logic                               int_n;
    logic                               rst_n;
    logic                               reg_en;
    logic                               wb_ack;
    logic [31:0]                        wb_dat;
  } csw_state_t;
endpackage : csw_pkg

// ==== rtl/csw_timers.sv ====
// cyclic sense and cyclic wake timers with mode control and wishbone registers
// Behaviour
// - a valid on-time code starts sensing at once on a mapped high side, unless that switch is disabled or the device is in fail-safe
// - before sensing starts a high side sits at its programmed initial level
// - on-time longer than period sets the spi failure flag
// - sleep request without a valid wake source goes straight to restart
// - wake input is sampled once, at the end of each on-time
// - a cyclic sense wake sets that input's wake flag
// - in normal or stop, sensed inputs show only sampled levels
// - level change pulses interrupt in normal or stop, wakes from sleep
// - every detected change outside restart signals, even with the flag still set
// - fail-safe stops sensing, turns high side off, switches to static sense
// - a high side fault disables that switch and its sensing
// - sleep request with uncleared wake, cyclic wake or drain-source flags wakes at once and pulses reset
// - cyclic wake interrupts periodically, or wakes the device from sleep
// - for cyclic wake the on-time code only enables; 000, 110, 111 disable
// - cyclic wake interrupts at each on-start except the very first
// - two independent timers, each for cyclic wake or mapped cyclic sense
// - a mapped high side switches on each period, from timer or sync pin
// - an input that differs from its last sample at the end of the on-time is a wake event
module csw_timers (
  // clock and reset
  input  wire logic                         core_clk_in,
  input  wire logic                         reset_in,
  // wishbone slave
  input  wire logic                         wb_cyc_in,
  input  wire logic                         wb_stb_in,
  input  wire logic                         wb_we_in,
  input  wire logic [3:0]                   wb_adr_in,
  input  wire logic [3:0]                   wb_sel_in,
  input  wire logic [31:0]                  wb_dat_in,
  output logic      [31:0]                  wb_dat_out,
  output logic                              wb_ack_out,
  // wake side pins and fault reports
  input  wire logic [csw_pkg::NUM_WK-1:0]   wake_input_in,
  input  wire logic                         external_sync_input_in,
  input  wire logic [csw_pkg::NUM_WK-1:0]   hs_fault_in,
  input  wire logic                         drain_source_fault_in,
  input  wire logic                         fail_safe_in,
  // outputs
  output logic      [csw_pkg::NUM_WK-1:0]   high_side_output_out,
  output logic                              interrupt_out_n_out,
  output logic                              reset_out_n_out,
  output logic                              main_regulator_en_out
);
  csw_pkg::csw_state_t q, d;

  logic [csw_pkg::NUM_TMR-1:0]                 en, wrap, on_end, mapped;
  logic [csw_pkg::NUM_TMR-1:0][csw_pkg::CW-1:0] on_t, per_t;
  logic [csw_pkg::NUM_WK-1:0]                  hs_act, wk_ev;
  logic [csw_pkg::NUM_TMR-1:0]                 cw_ev;
  logic                                        tick, any_ev, wr, rd, sync_rise, bad_wr;
  logic                                        wake_src, dirty, low_pwr;

  // per-timer decode and counting
  always_comb begin
    tick      = (q.tick_cnt == 12'(csw_pkg::TICK_CYC - 1));
    sync_rise = external_sync_input_in && !q.sync_prev;
    for (int t = 0; t < csw_pkg::NUM_TMR; t++) begin
      // three codes disable, all others just enable
      en[t]     = !(q.tmr_cfg[t].on inside {csw_pkg::ON_OFF0, csw_pkg::ON_OFF6,
                                          csw_pkg::ON_OFF7});
      on_t[t]   = csw_pkg::ON_TICKS[q.tmr_cfg[t].on];
      per_t[t]  = csw_pkg::PERIOD_TICKS[q.tmr_cfg[t].period];
      // sync only steers timer 0; it restarts the period and holds at its end
      if (t == 0 && q.sync_sel) begin
        wrap[t] = en[t] && sync_rise;
      end else begin
        wrap[t] = en[t] && tick && (q.tmr_cnt[t] == per_t[t] - 15'h0001);
      end
      on_end[t] = en[t] && tick && (q.tmr_cnt[t] + 15'h0001 == on_t[t]);
      mapped[t] = 1'b0;
      for (int i = 0; i < csw_pkg::NUM_WK; i++) begin
        if (q.hs_map[i] == 2'(t + 1)) begin
          mapped[t] = 1'b1;
        end
      end
      // first on-time begins at enable and is silent; each wrap is a new on-start
      cw_ev[t] = wrap[t] && !mapped[t];
    end
  end

  // high side activity and wake detection
  always_comb begin
    low_pwr = (q.mode == csw_pkg::MODE_FAILSAFE);
    for (int i = 0; i < csw_pkg::NUM_WK; i++) begin
      hs_act[i] = 1'b0;
      wk_ev[i]  = 1'b0;
      for (int t = 0; t < csw_pkg::NUM_TMR; t++) begin
        if (q.hs_map[i] == 2'(t + 1) && en[t] && !q.hs_dis[i] && !low_pwr) begin
          hs_act[i] = 1'b1;
          // compare with the last stored sample only at the end of the on-time
          if (on_end[t] && wake_input_in[i] != q.wk_prev[i]) begin
            wk_ev[i] = 1'b1;
          end
        end
      end
      // static sensing, also what fail-safe converts an input to
      if (!hs_act[i] && (q.static_en[i] || low_pwr) && wake_input_in[i] != q.wk_prev[i]) begin
        wk_ev[i] = 1'b1;
      end
    end
    any_ev = |wk_ev || |cw_ev;
    wake_src = |q.static_en;
    for (int t = 0; t < csw_pkg::NUM_TMR; t++) begin
      if (en[t] && !mapped[t]) begin
        wake_src = 1'b1;
      end
    end
    for (int i = 0; i < csw_pkg::NUM_WK; i++) begin
      if (hs_act[i]) begin
        wake_src = 1'b1;
      end
    end
    dirty = |q.wk_flag || |q.cw_flag || q.ds_flag;
  end

  // bus decode: one request per ack, unmapped offsets read zero
  always_comb begin
    wr     = wb_cyc_in && wb_stb_in && !q.wb_ack && wb_we_in && (&wb_sel_in);
    rd     = wb_cyc_in && wb_stb_in && !q.wb_ack;
    bad_wr = 1'b0;
    for (int t = 0; t < csw_pkg::NUM_TMR; t++) begin
      if (!(wb_dat_in[t*csw_pkg::TMR_STRIDE+csw_pkg::TMR_ON_POS +: 3] inside
            {csw_pkg::ON_OFF0, csw_pkg::ON_OFF6, csw_pkg::ON_OFF7}) &&
          csw_pkg::ON_TICKS[wb_dat_in[t*csw_pkg::TMR_STRIDE+csw_pkg::TMR_ON_POS +: 3]] >
          csw_pkg::PERIOD_TICKS[wb_dat_in[t*csw_pkg::TMR_STRIDE+csw_pkg::TMR_PER_POS +: 3]]) begin
        bad_wr = wr && (wb_adr_in == csw_pkg::ADDR_TIMER);
      end
    end
  end

  // next state
  always_comb begin
    d           = q;
    d.int_n     = 1'b1;
    d.wb_ack    = rd;
    d.sync_prev = external_sync_input_in;
    d.tick_cnt  = (tick || !(|en)) ? 12'h000 : q.tick_cnt + 12'h001; // rests while timers off
    // timers count ticks; one started beside a running timer gets a short first tick
    for (int t = 0; t < csw_pkg::NUM_TMR; t++) begin
      if (!en[t] || wrap[t]) begin
        d.tmr_cnt[t] = '0;
      end else if (tick && q.tmr_cnt[t] != per_t[t] - 15'h0001) begin
        d.tmr_cnt[t] = q.tmr_cnt[t] + 15'h0001;
      end
    end
    // high side drive and sampling
    for (int i = 0; i < csw_pkg::NUM_WK; i++) begin
      if (hs_act[i]) begin
        d.hs_out[i] = 1'b0;
        for (int t = 0; t < csw_pkg::NUM_TMR; t++) begin
          if (q.hs_map[i] == 2'(t + 1)) begin
            d.hs_out[i] = (q.tmr_cnt[t] < on_t[t]);
            if (on_end[t]) begin
              d.wk_prev[i] = wake_input_in[i];
              d.wk_lvl[i]  = wake_input_in[i];
            end
          end
        end
      end else begin
        d.hs_out[i]  = low_pwr ? 1'b0 : q.hs_init[i];
        d.wk_prev[i] = wake_input_in[i];
        d.wk_lvl[i]  = wake_input_in[i];
      end
    end
    // restart holds reset low for a fixed time, then normal
    if (q.mode == csw_pkg::MODE_RESTART) begin
      d.rst_cnt = q.rst_cnt + 9'h001;
      if (q.rst_cnt == 9'(csw_pkg::RESTART_CYC - 1)) begin
        d.mode   = csw_pkg::MODE_NORMAL;
        d.rst_n  = 1'b1;
        d.reg_en = 1'b1;
      end
    end
    // register writes; wake, cyclic wake, drain-source and failure status bits are write-one-to-clear
    if (wr) begin
      unique case (wb_adr_in)
        csw_pkg::ADDR_TIMER: begin
          for (int t = 0; t < csw_pkg::NUM_TMR; t++) begin
            d.tmr_cfg[t].on     = wb_dat_in[t*csw_pkg::TMR_STRIDE+csw_pkg::TMR_ON_POS +: 3];
            d.tmr_cfg[t].period = wb_dat_in[t*csw_pkg::TMR_STRIDE+csw_pkg::TMR_PER_POS +: 3];
          end
        end
        csw_pkg::ADDR_HSCFG: begin
          for (int i = 0; i < csw_pkg::NUM_WK; i++) begin
            d.hs_map[i]    = wb_dat_in[i*csw_pkg::HS_STRIDE +: 2];
            d.hs_init[i]   = wb_dat_in[i*csw_pkg::HS_STRIDE+csw_pkg::HS_INIT_POS];
            d.static_en[i] = wb_dat_in[csw_pkg::HS_STAT_POS+i];
          end
          d.hs_dis = '0; // rewriting the mapping re-arms a faulted switch
        end
        csw_pkg::ADDR_MODE: begin
          d.sync_sel = wb_dat_in[csw_pkg::MODE_SYNC_POS];
          if (q.mode == csw_pkg::MODE_NORMAL || q.mode == csw_pkg::MODE_STOP) begin
            unique case (wb_dat_in[1:0])
              csw_pkg::REQ_NORMAL: d.mode = csw_pkg::MODE_NORMAL;
              csw_pkg::REQ_STOP: begin
                if (q.mode == csw_pkg::MODE_NORMAL) begin
                  d.mode = csw_pkg::MODE_STOP;
                end
              end
              csw_pkg::REQ_SLEEP: begin
                d.rst_n  = 1'b0;
                d.reg_en = 1'b0;
                if (q.mode == csw_pkg::MODE_STOP) begin
                  d.mode     = csw_pkg::MODE_RESTART;
                  d.spi_fail = 1'b1;
                end else if (dirty || !wake_src) begin
                  d.mode = csw_pkg::MODE_RESTART;
                end else begin
                  d.mode = csw_pkg::MODE_SLEEP;
                end
                d.rst_cnt = '0;
              end
              default: d.mode = q.mode;
            endcase
          end
        end
        csw_pkg::ADDR_STAT: begin
          d.wk_flag  = q.wk_flag & ~wb_dat_in[0 +: csw_pkg::NUM_WK];
          d.cw_flag  = q.cw_flag & ~wb_dat_in[csw_pkg::ST_CW_POS +: csw_pkg::NUM_TMR];
          d.ds_flag  = q.ds_flag & ~wb_dat_in[csw_pkg::ST_DS_POS];
          d.spi_fail = d.spi_fail & ~wb_dat_in[csw_pkg::ST_FAIL_POS];
        end
        default: d.mode = d.mode;
      endcase
    end
    // hardware sets come after clears so a coincident event is kept
    d.spi_fail = d.spi_fail | bad_wr;
    d.wk_flag  = d.wk_flag | wk_ev;
    d.cw_flag  = d.cw_flag | cw_ev;
    d.ds_flag  = d.ds_flag | drain_source_fault_in;
    d.hs_dis   = d.hs_dis | (hs_fault_in & {csw_pkg::NUM_WK{!low_pwr}});
    // every event outside restart signals, whether or not its flag was already set
    if (any_ev) begin
      if (q.mode == csw_pkg::MODE_NORMAL || q.mode == csw_pkg::MODE_STOP) begin
        d.int_n = 1'b0;
      end else if (q.mode == csw_pkg::MODE_SLEEP || q.mode == csw_pkg::MODE_FAILSAFE) begin
        d.mode    = csw_pkg::MODE_RESTART;
        d.reg_en  = 1'b1;
        d.rst_n   = 1'b0;
        d.rst_cnt = '0;
      end
    end
    // fail-safe entry drops all timers back to their off codes
    if (fail_safe_in && !low_pwr) begin
      d.mode   = csw_pkg::MODE_FAILSAFE;
      d.rst_n  = 1'b0;
      d.reg_en = 1'b0;
      for (int t = 0; t < csw_pkg::NUM_TMR; t++) begin
        d.tmr_cfg[t].on = csw_pkg::ON_OFF0;
      end
    end
    // read data
    d.wb_dat = '0;
    if (rd) begin
      unique case (wb_adr_in)
        csw_pkg::ADDR_TIMER: begin
          for (int t = 0; t < csw_pkg::NUM_TMR; t++) begin
            d.wb_dat[t*csw_pkg::TMR_STRIDE+csw_pkg::TMR_ON_POS +: 3]  = q.tmr_cfg[t].on;
            d.wb_dat[t*csw_pkg::TMR_STRIDE+csw_pkg::TMR_PER_POS +: 3] = q.tmr_cfg[t].period;
          end
        end
        csw_pkg::ADDR_HSCFG: begin
          for (int i = 0; i < csw_pkg::NUM_WK; i++) begin
            d.wb_dat[i*csw_pkg::HS_STRIDE +: 2]                  = q.hs_map[i];
            d.wb_dat[i*csw_pkg::HS_STRIDE+csw_pkg::HS_INIT_POS]  = q.hs_init[i];
            d.wb_dat[csw_pkg::HS_STAT_POS+i]                     = q.static_en[i];
          end
        end
        csw_pkg::ADDR_MODE: d.wb_dat[csw_pkg::MODE_SYNC_POS] = q.sync_sel;
        csw_pkg::ADDR_STAT: begin
          d.wb_dat[0 +: csw_pkg::NUM_WK]                    = q.wk_flag;
          d.wb_dat[csw_pkg::ST_CW_POS +: csw_pkg::NUM_TMR]  = q.cw_flag;
          d.wb_dat[csw_pkg::ST_DS_POS]                      = q.ds_flag;
          d.wb_dat[csw_pkg::ST_FAIL_POS]                    = q.spi_fail;
          d.wb_dat[csw_pkg::ST_LVL_POS +: csw_pkg::NUM_WK]  = q.wk_lvl;
          d.wb_dat[csw_pkg::ST_MODE_POS +: 5]               = q.mode;
          d.wb_dat[csw_pkg::ST_DIS_POS +: csw_pkg::NUM_WK]  = q.hs_dis;
        end
        default: d.wb_dat = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      q        <= '0;
      q.mode   <= csw_pkg::MODE_NORMAL;
      q.int_n  <= 1'b1;
      q.rst_n  <= 1'b1;
      q.reg_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_out            = q.wb_dat;
  assign wb_ack_out            = q.wb_ack;
  assign high_side_output_out  = q.hs_out;
  assign interrupt_out_n_out   = q.int_n;
  assign reset_out_n_out       = q.rst_n;
  assign main_regulator_en_out = q.reg_en;

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  spi_fail_set_a: assert property (bad_wr |=> q.spi_fail)
    else $error("bad on-time write did not set failure flag");
  hs_init_level_a: assert property (!hs_act[0] && !low_pwr |=> high_side_output_out[0] ==
                                    $past(q.hs_init[0]))
    else $error("idle high side not at initial level");
  failsafe_hs_off_a: assert property (low_pwr && $past(low_pwr) |-> high_side_output_out == '0)
    else $error("high side on in fail-safe");
  wake_flag_set_a: assert property (wk_ev[0] |=> q.wk_flag[0])
    else $error("wake event lost its flag");
  int_pulse_a: assert property (any_ev && q.mode == csw_pkg::MODE_NORMAL && !fail_safe_in
                                |=> !interrupt_out_n_out ##1
                                (interrupt_out_n_out || $past(any_ev)))
    else $error("interrupt pulse missing");
  sleep_wake_a: assert property (any_ev && q.mode == csw_pkg::MODE_SLEEP && !fail_safe_in
                                 |=> q.mode == csw_pkg::MODE_RESTART && !reset_out_n_out)
    else $error("sleep wake did not restart");
  sample_end_a: assert property (wk_ev[0] && hs_act[0] |-> tick)
    else $error("sample outside end of on-time");
  fault_dis_a: assert property (hs_fault_in[0] && !low_pwr && !fail_safe_in |=> q.hs_dis[0] ##1
                                high_side_output_out[0] == $past(q.hs_init[0]))
    else $error("faulted switch not disabled");
  dirty_sleep_a: assert property (wr && wb_adr_in == csw_pkg::ADDR_MODE &&
                                  wb_dat_in[1:0] == csw_pkg::REQ_SLEEP && dirty && !any_ev &&
                                  q.mode == csw_pkg::MODE_NORMAL && !fail_safe_in
                                  |=> q.mode == csw_pkg::MODE_RESTART [*3])
    else $error("sleep taken with flags set");
  wb_ack_a: assert property (rd |=> wb_ack_out ##1 !wb_ack_out)
    else $error("bus ack not one cycle");

  cw_int_c: cover property (cw_ev[0] && q.mode == csw_pkg::MODE_NORMAL);
  sense_wake_c: cover property (wk_ev[0] && hs_act[0] && q.mode == csw_pkg::MODE_SLEEP);
  failsafe_c: cover property (fail_safe_in && q.mode == csw_pkg::MODE_NORMAL);
endmodule : csw_timers

// ==== dv/csw_wake_switch.sv ====
// far side model: wake switches fed by the cyclic sense high sides
module csw_wake_switch (
  // supply from the high sides and contact state from the bench
  input  wire logic [1:0] hs_in,
  input  wire logic [1:0] closed_in,
  // wake input levels
  output logic      [1:0] wake_out
);
  // pull-down: an unpowered contact reads low, so no stale level survives
  assign wake_out = hs_in & closed_in;
endmodule : csw_wake_switch

// ==== dv/tb_cyclic_sense_wake_timers.sv ====
// self-checking bench for the cyclic sense and wake timers
module tb_cyclic_sense_wake_timers;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] TMR = csw_pkg::ADDR_TIMER;
  localparam logic [3:0] HSC = csw_pkg::ADDR_HSCFG;
  localparam logic [3:0] MOD = csw_pkg::ADDR_MODE;
  localparam logic [3:0] STA = csw_pkg::ADDR_STAT;
  // bus, pins and bookkeeping
  logic        clk, rst, cyc, stb, we, ds, fs, sy, ack, int_n, rst_n, reg_en, e;
  logic [3:0]  adr, sel, wsel;
  logic [31:0] wdat, rdat, rd, seed;
  logic [1:0]  hs, wk, flt, sw;
  logic [2:0]  on, per;
  int          mismatches, checked, ints, ints0, cycles, n;
  time         t_up, t_dn;

  csw_timers dut (.core_clk_in(clk), .reset_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .wake_input_in(wk), .external_sync_input_in(sy),
    .hs_fault_in(flt), .drain_source_fault_in(ds), .fail_safe_in(fs),
    .high_side_output_out(hs), .interrupt_out_n_out(int_n), .reset_out_n_out(rst_n),
    .main_regulator_en_out(reg_en));
  csw_wake_switch far (.hs_in(hs), .closed_in(sw), .wake_out(wk));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // interrupt pulses and hang limit; the run needs about 20000 cycles
  always @(posedge clk) begin
    cycles++;
    if (!rst && int_n === 1'b0) ints++;
    if (cycles == 60000) begin
      mismatches++;
      test_done();
    end
  end
  // edges of high side 0 give its on-time
  always @(posedge hs[0]) t_up = $time;
  always @(negedge hs[0]) t_dn = $time;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // one classic cycle; held until ack is seen at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= wsel;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 40);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k >= 40) mismatches++;
  endtask : bus

  task automatic stat(input string nm, input logic [31:0] m, input logic [31:0] ex);
    bus(1'b0, STA, '0);
    chk(nm, ex, rd & m);
  endtask : stat

  // cycles that the reset output stays low in restart
  task automatic restart_len;
    n = 0;
    while (rst_n !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (rst_n !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
  endtask : restart_len

  task automatic do_reset;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic tend(input string nm);
    $display("test %s finished", nm);
  endtask : tend

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  initial begin
    {cyc, stb, we, ds, fs, sy, rst} = 7'h01;
    {adr, wdat, flt, sw} = '0;
    {sel, wsel} = 8'hff;
    seed = 32'h0001_0a59;
    {mismatches, checked, ints, cycles} = '0;
    do_reset();
    // defaults, an unmapped place and a partial-width write
    stat("mode", 32'h001f_0000, 32'h0001_0000);
    seed = xs(seed);
    bus(1'b1, 4'h2, seed);
    bus(1'b0, 4'h2, '0);
    chk("unmapped", '0, rd);
    wsel = 4'h3;
    bus(1'b1, TMR, 32'h11);
    wsel = 4'hf;
    bus(1'b0, TMR, '0);
    chk("timer", '0, rd);
    tend("registers");
    // on-time against period on timer 1: one boundary pair, then random codes
    ints0 = ints;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      on = (i == 0) ? 3'h5 : (i == 1) ? 3'h4 : seed[2:0];
      per = (i < 2) ? 3'h0 : seed[6:4];
      e = csw_pkg::ON_TICKS[on] > csw_pkg::PERIOD_TICKS[per];
      bus(1'b1, TMR, 32'({on, 1'b0, per, 8'h00}));
      stat("spi_fail", 32'h20, 32'(e) << 5);
      bus(1'b1, STA, 32'h3f);
    end
    bus(1'b1, TMR, '0);
    chk("first_wake_int", ints0, ints);
    tend("period_vs_on");
    // sensing on high side 0: level, mapping, then timer
    bus(1'b1, HSC, 32'h5);
    @(posedge clk);
    chk("hs_init", 32'h1, hs);
    bus(1'b1, HSC, 32'h1);
    @(posedge clk);
    chk("hs_init", 32'h0, hs);
    sw <= 2'b01;
    ints0 = ints;
    bus(1'b1, TMR, 32'h10);
    repeat (2) @(posedge clk);
    chk("hs_on", 32'h1, hs);
    repeat (1000) @(posedge clk);
    stat("early", 32'h101, '0);
    n = 0;
    while (hs[0] !== 1'b0 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
    chk("on_time", csw_pkg::ON_TICKS[1] * csw_pkg::TICK_CYC, 32'((t_dn - t_up) / 25));
    chk("sense_int", ints0 + 1, ints);
    stat("sense_flag", 32'h101, 32'h101);
    // a sync rise restarts timer 0 and with it the on-phase
    bus(1'b1, MOD, 32'h10);
    sy <= 1'b1;
    repeat (3) @(posedge clk);
    chk("sync_on", 32'h1, hs);
    sy <= 1'b0;
    bus(1'b1, MOD, 32'h0);
    tend("cyclic_sense");
    // sleep with the wake flag still set restarts at once; then stop to sleep
    bus(1'b1, MOD, 32'(csw_pkg::REQ_SLEEP));
    restart_len();
    chk("restart", csw_pkg::RESTART_CYC, n);
    bus(1'b1, STA, 32'h3f);
    bus(1'b1, MOD, 32'(csw_pkg::REQ_STOP));
    stat("stop", 32'h001f_0000, 32'h0002_0000);
    bus(1'b1, MOD, 32'(csw_pkg::REQ_SLEEP));
    restart_len();
    stat("stop_sleep", 32'h001f_0020, 32'h0001_0020);
    bus(1'b1, STA, 32'h3f);
    tend("sleep_requests");
    // disabling code mid on-phase, then a high side fault
    ints0 = ints;
    bus(1'b1, TMR, '0);
    bus(1'b1, TMR, 32'h10);
    repeat (1000) @(posedge clk);
    bus(1'b1, TMR, '0);
    @(posedge clk);
    chk("hs_stop", 32'h0, hs);
    repeat (4000) @(posedge clk);
    chk("no_int", ints0, ints);
    bus(1'b1, TMR, 32'h10);
    repeat (100) @(posedge clk);
    flt <= 2'b01;
    @(posedge clk);
    flt <= 2'b00;
    repeat (3) @(posedge clk);
    chk("hs_fault", 32'h0, hs);
    ds <= 1'b1;
    @(posedge clk);
    ds <= 1'b0;
    stat("faults", 32'h0100_0010, 32'h0100_0010);
    tend("stops");
    // every on-time code of an unmapped timer as the only wake source
    for (int c = 0; c < 8; c++) begin
      do_reset();
      bus(1'b1, TMR, 32'h700 | (32'(c) << 12));
      bus(1'b1, MOD, 32'(csw_pkg::REQ_SLEEP));
      repeat (500) @(posedge clk);
      chk("regulator", (c == 0 || c > 5) ? 32'h1 : 32'h0, reg_en);
    end
    tend("wake_codes");
    // cyclic sense as the only wake source carries the device out of sleep
    do_reset();
    bus(1'b1, HSC, 32'h1);
    bus(1'b1, TMR, 32'h10);
    bus(1'b1, MOD, 32'(csw_pkg::REQ_SLEEP));
    stat("sleep", 32'h001f_0000, 32'h0004_0000);
    repeat (4500) @(posedge clk);
    stat("sense_wake", 32'h001f_0001, 32'h0001_0001);
    chk("regulator_up", 32'h1, reg_en);
    tend("sleep_sense");
    // fail-safe during an on-phase
    do_reset();
    bus(1'b1, HSC, 32'h1);
    bus(1'b1, TMR, 32'h10);
    repeat (100) @(posedge clk);
    fs <= 1'b1;
    repeat (3) @(posedge clk);
    chk("fail_safe_hs", 32'h0, hs);
    bus(1'b0, TMR, '0);
    chk("fs_timer", '0, rd);
    tend("fail_safe");
    test_done();
  end
endmodule : tb_cyclic_sense_wake_timers
